// ==== shared/ddsr_pkg.sv ====
`default_nettype none
package ddsr_pkg;
    // clock and timing
    localparam int CLK_MHZ = 50;
    localparam int STRETCH_UNIT_US = 1000;
    localparam int STRETCH_UNIT_CYC = STRETCH_UNIT_US * CLK_MHZ;
    localparam int DEGLITCH_NS = 2000;
    localparam int DEGLITCH_CYC = (DEGLITCH_NS * CLK_MHZ) / 1000;
    localparam int STRETCH_W = 20;
    localparam int DEGLITCH_W = 8;
    localparam logic [DEGLITCH_W-1:0] DEGLITCH_LAST = DEGLITCH_W'(DEGLITCH_CYC - 1);
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [4:0] BITS_MAX = 5'h1F;

    // response word layout
    localparam logic [1:0] CLASS_REG = 2'h0;
    localparam logic [1:0] CLASS_CMD = 2'h1;
    localparam logic [1:0] CLASS_DIAG = 2'h2;
    localparam logic [1:0] CLASS_STAT = 2'h3;
    localparam logic [2:0] FAULT_TOP = 3'h7;
    localparam logic [1:0] CAUSE_PARITY = 2'h0;
    localparam logic [1:0] CAUSE_COUNT = 2'h2;
    localparam logic [15:0] RESP_AFTER_RESET = 16'h0000;
    localparam logic [7:0] SOFT_CODE_FIRST = 8'hAA;
    localparam logic [7:0] SOFT_CODE_SECOND = 8'h55;
    localparam int BIT_RW = 12;
    localparam int BIT_SEL = 11;
    localparam int BIT_COND = 10;
    localparam int BIT_STR = 8;

    // register map and interrupt bits
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h00;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h04;
    localparam logic [7:0] OFF_LINK_STATE = 8'h08;
    localparam logic [7:0] OFF_LAST_FRAME = 8'h0C;
    localparam int IRQ_W = 5;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 5'h00;
    localparam int IRQ_FRAME = 0;
    localparam int IRQ_FAULT = 1;
    localparam int IRQ_SOFT = 2;
    localparam int IRQ_HARD = 3;
    localparam int IRQ_ARM = 4;

    typedef enum logic [2:0] {SEL_ZERO, SEL_REG, SEL_CMD, SEL_DIAG, SEL_STAT, SEL_FAULT} ddsr_sel_t;

    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic hready;
        logic [31:0] hwdata;
    } ddsr_ahb_req_t;

    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic mosi;
    } ddsr_spi_in_t;

    typedef struct packed {
        logic [3:0] arm_chan;
        logic deploy_enable_pin;
        logic external_reset_pin_n;
        logic ground_loss;
        logic reference_resistor_fault;
    } ddsr_pins_t;
endpackage
`default_nettype wire

// ==== src/ddsr_core.sv ====
// Overview of operation
// RQ1: top two bits give response class
// RQ2: register response is the default reply
// RQ3: first response after reset is zero
// RQ4: bit 12 echoes read/write, bit 13 zero
// RQ5: bit 11 repeats previous command bit 11
// RQ6: bit 10 reports stored deployment condition
// RQ7: bits 9:8 report pulse stretch code
// RQ8: hard flag cleared by resets, set once read
// RQ9: soft flag set after valid soft reset
// RQ10: after soft reset, register reply ends 1
// RQ11: register replies follow the summary values
// RQ12: command reply bit 12 shows deploy enable
// RQ13: command reply bits 9:8 show arming pairs
// RQ14: deploy-started stretch never asserts arming flag
// RQ15: arming flag ORs the pair's two channels
// RQ16: bits 3:0 copy last command-mode message
// RQ17: fault reply has top three bits set
// RQ18: reply shifts MSB first in next frame
`default_nettype none
module ddsr_core #(
    parameter int STRETCH_CYC = ddsr_pkg::STRETCH_UNIT_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire ddsr_pkg::ddsr_ahb_req_t ahb,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire ddsr_pkg::ddsr_spi_in_t spi_in,
    output logic miso,
    output logic miso_oe_n,
    input wire ddsr_pkg::ddsr_pins_t pins,
    output logic irq
);
    import ddsr_pkg::*;

    typedef struct packed {
        logic [1:0] sclk_s;
        logic [1:0] cs_s;
        logic [1:0] mosi_s;
        logic [1:0] rst_s;
        logic [1:0] gnd_s;
        logic [1:0] rref_s;
        logic [1:0] deploy_enable_pin_s;
        logic [1:0][3:0] arm_s;
        logic sclk_q;
        logic cs_q;
        logic in_frame;
        logic [15:0] rx;
        logic [15:0] tx;
        logic [4:0] bits;
        logic miso;
        logic miso_oe_n;
        ddsr_sel_t sel;
        logic [1:0] fault_cause;
        logic hard_flag;
        logic soft_flag;
        logic aa_seen;
        logic wr_echo;
        logic sel_bit11;
        logic deploy_cond;
        logic [1:0] stretch_code;
        logic [3:0] deploy_cmd;
        logic [1:0] pair_q;
        logic [1:0][STRETCH_W-1:0] stretch_cnt;
        logic [1:0][DEGLITCH_W-1:0] dg_cnt;
        logic [1:0] arm_flag;
        logic [15:0] last_rx;
        logic [15:0] last_tx;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic irq;
        logic wr_q;
        logic [7:0] addr_q;
        logic [31:0] hrdata;
        logic hreadyout;
    } ddsr_state_t;

    ddsr_state_t s;
    ddsr_state_t n;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;
    logic link_reset;
    logic accept;
    logic pair_raw;
    logic stretched;
    logic [IRQ_W-1:0] ev;

    // builds the reply word from live state, so pin levels are current at frame start
    function automatic logic [15:0] compose(input ddsr_state_t st);
        logic [15:0] w;
        w = RESP_AFTER_RESET;
        case (st.sel)
            SEL_ZERO: w = RESP_AFTER_RESET; // RQ3
            SEL_REG: w = {CLASS_REG, 1'b0, st.wr_echo, st.sel_bit11, st.deploy_cond,
                st.stretch_code, 5'h00, 1'b1, st.hard_flag, st.soft_flag}; // RQ4 RQ5 RQ6 RQ7 RQ11
            SEL_CMD: w = {CLASS_CMD, 1'b0, st.deploy_enable_pin_s[1], 2'h0, st.arm_flag, 4'h0,
                st.deploy_cmd}; // RQ12 RQ13 RQ16
            SEL_DIAG: w = {CLASS_DIAG, 1'b0, st.deploy_enable_pin_s[1], 12'h000};
            SEL_STAT: w = {CLASS_STAT, 1'b0, st.deploy_enable_pin_s[1], 2'h0, st.arm_flag, 8'h00};
            SEL_FAULT: w = {FAULT_TOP, st.fault_cause, 11'h000}; // RQ17
            default: w = RESP_AFTER_RESET;
        endcase
        return w;
    endfunction

    // software-visible word at a given offset; unmapped offsets read zero
    function automatic logic [31:0] read_word(input ddsr_state_t st, input logic [7:0] a);
        logic [31:0] d;
        d = 32'h0000_0000;
        case (a)
            OFF_IRQ_STATUS: d = {27'h0000000, st.irq_stat};
            OFF_IRQ_MASK: d = {27'h0000000, st.irq_mask};
            OFF_LINK_STATE: d = {16'h0000, st.in_frame, st.hard_flag, st.soft_flag, st.aa_seen,
                st.arm_flag, st.deploy_enable_pin_s[1], st.deploy_cond, st.stretch_code, 2'h0,
                st.deploy_cmd};
            OFF_LAST_FRAME: d = {st.last_rx, st.last_tx};
            default: d = 32'h0000_0000;
        endcase
        return d;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb
    begin
        n = s;
        ev = '0;
        pair_raw = 1'b0;
        stretched = 1'b0;

        // two-stage synchronisers for everything arriving from pins
        n.sclk_s = {s.sclk_s[0], spi_in.sclk};
        n.cs_s = {s.cs_s[0], spi_in.cs_n};
        n.mosi_s = {s.mosi_s[0], spi_in.mosi};
        n.rst_s = {s.rst_s[0], pins.external_reset_pin_n};
        n.gnd_s = {s.gnd_s[0], pins.ground_loss};
        n.rref_s = {s.rref_s[0], pins.reference_resistor_fault};
        n.deploy_enable_pin_s = {s.deploy_enable_pin_s[0], pins.deploy_enable_pin};
        n.arm_s = {s.arm_s[0], pins.arm_chan};
        n.sclk_q = s.sclk_s[1];
        n.cs_q = s.cs_s[1];
        sclk_rise = s.sclk_s[1] & ~s.sclk_q;
        sclk_fall = ~s.sclk_s[1] & s.sclk_q;
        cs_fall = ~s.cs_s[1] & s.cs_q;
        cs_rise = s.cs_s[1] & ~s.cs_q;
        link_reset = ~s.rst_s[1] | s.gnd_s[1];

        // bus data phase: the write lands before events so a same-cycle event wins
        if (s.wr_q)
        begin
            case (s.addr_q)
                OFF_IRQ_STATUS: n.irq_stat = s.irq_stat & ~ahb.hwdata[IRQ_W-1:0];
                OFF_IRQ_MASK: n.irq_mask = ahb.hwdata[IRQ_W-1:0];
                default: n.irq_mask = n.irq_mask;
            endcase
        end

        // frame start loads the reply chosen by the previous frame
        if (cs_fall)
        begin
            n.in_frame = 1'b1;
            n.tx = compose(s);
            n.last_tx = n.tx;
            n.miso = n.tx[15]; // RQ18
            n.miso_oe_n = 1'b0;
            n.bits = '0;
            n.rx = '0;
        end
        else if (s.in_frame && !s.cs_s[1])
        begin
            // mode 0: sample on rising sclk, shift out on falling sclk
            if (sclk_rise)
            begin
                n.rx = {s.rx[14:0], s.mosi_s[1]};
                n.bits = (s.bits == BITS_MAX) ? s.bits : 5'(s.bits + 5'h01);
            end
            if (sclk_fall)
            begin
                n.tx = {s.tx[14:0], 1'b0};
                n.miso = s.tx[14]; // RQ18
            end
        end

        // frame end: judge the command and pick the next reply
        if (cs_rise && s.in_frame)
        begin
            n.in_frame = 1'b0;
            n.miso_oe_n = 1'b1;
            n.miso = 1'b0;
            n.last_rx = s.rx;
            n.soft_flag = 1'b0; // RQ9
            n.aa_seen = 1'b0;
            ev[IRQ_FRAME] = 1'b1;
            if (s.last_tx[15:14] == CLASS_REG) // tx is shifted empty by now, so judge the loaded word
            begin
                n.hard_flag = 1'b1; // RQ8
            end
            if (s.bits != FRAME_BITS)
            begin
                n.sel = SEL_FAULT; // RQ17
                n.fault_cause = CAUSE_COUNT;
                ev[IRQ_FAULT] = 1'b1;
            end
            else if (!(^s.rx))
            begin
                n.sel = SEL_FAULT; // RQ17
                n.fault_cause = CAUSE_PARITY;
                ev[IRQ_FAULT] = 1'b1;
            end
            else
            begin
                case (s.rx[15:14])
                    CLASS_REG:
                    begin
                        n.sel = SEL_REG; // RQ2
                        n.wr_echo = s.rx[BIT_RW]; // RQ4
                        n.sel_bit11 = s.rx[BIT_SEL]; // RQ5
                        if (s.rx[BIT_RW] && s.rx[BIT_SEL])
                        begin
                            if (s.rx[7:0] == SOFT_CODE_FIRST)
                            begin
                                n.aa_seen = 1'b1;
                            end
                            else if (s.rx[7:0] == SOFT_CODE_SECOND && s.aa_seen)
                            begin
                                // soft reset: settings back to defaults, hard flag kept
                                n.soft_flag = 1'b1; // RQ9 RQ10
                                n.wr_echo = 1'b0;
                                n.sel_bit11 = 1'b0;
                                n.deploy_cond = 1'b0;
                                n.stretch_code = 2'h0;
                                n.deploy_cmd = 4'h0;
                                ev[IRQ_SOFT] = 1'b1;
                            end
                        end
                        else if (s.rx[BIT_RW])
                        begin
                            n.deploy_cond = s.rx[BIT_COND]; // RQ6
                            n.stretch_code = s.rx[BIT_STR+1:BIT_STR]; // RQ7
                        end
                    end
                    CLASS_CMD:
                    begin
                        n.sel = SEL_CMD;
                        n.deploy_cmd = s.rx[3:0]; // RQ16
                    end
                    CLASS_DIAG: n.sel = SEL_DIAG;
                    default: n.sel = SEL_STAT;
                endcase
            end
        end

        // arming: stretch only follows the arming inputs, deploy commands never start one
        for (int k = 0; k < 2; k++)
        begin
            pair_raw = s.arm_s[1][2*k] | s.arm_s[1][2*k+1]; // RQ15
            n.pair_q[k] = pair_raw;
            if (!pair_raw && s.pair_q[k])
            begin
                n.stretch_cnt[k] = STRETCH_W'(int'(s.stretch_code) * STRETCH_CYC); // RQ14
            end
            else if (pair_raw)
            begin
                n.stretch_cnt[k] = '0;
            end
            else if (s.stretch_cnt[k] != '0)
            begin
                n.stretch_cnt[k] = s.stretch_cnt[k] - 1'b1;
            end
            stretched = pair_raw | (s.stretch_cnt[k] != '0); // RQ13
            // flag moves only after the new level has been stable for the deglitch time
            if (stretched != s.arm_flag[k])
            begin
                if (s.dg_cnt[k] == DEGLITCH_LAST)
                begin
                    n.arm_flag[k] = stretched; // RQ13
                    n.dg_cnt[k] = '0;
                    ev[IRQ_ARM] = 1'b1;
                end
                else
                begin
                    n.dg_cnt[k] = s.dg_cnt[k] + 1'b1;
                end
            end
            else
            begin
                n.dg_cnt[k] = '0;
            end
        end

        // reference resistor fault only drops the hard flag
        if (s.rref_s[1])
        begin
            ev[IRQ_HARD] = s.hard_flag;
            n.hard_flag = 1'b0; // RQ8
        end

        // reset pin or ground loss restart the link side as a power-on would
        if (link_reset)
        begin
            ev[IRQ_HARD] = s.hard_flag;
            n.in_frame = 1'b0;
            n.miso = 1'b0;
            n.miso_oe_n = 1'b1;
            n.bits = '0;
            n.sel = SEL_ZERO; // RQ3
            n.fault_cause = CAUSE_PARITY;
            n.hard_flag = 1'b0; // RQ8
            n.soft_flag = 1'b0;
            n.aa_seen = 1'b0;
            n.wr_echo = 1'b0;
            n.sel_bit11 = 1'b0;
            n.deploy_cond = 1'b0;
            n.stretch_code = 2'h0;
            n.deploy_cmd = 4'h0;
            n.stretch_cnt = '0;
            n.dg_cnt = '0;
            n.arm_flag = 2'h0;
        end

        // sticky status, mask and interrupt level
        n.irq_stat = n.irq_stat | ev;
        n.irq = |(n.irq_stat & n.irq_mask);

        // bus address phase; zero wait states, read data from post-write state
        accept = ahb.hsel & ahb.htrans[1] & ahb.hready;
        n.wr_q = accept & ahb.hwrite;
        n.addr_q = accept ? ahb.haddr[7:0] : s.addr_q;
        if (accept && !ahb.hwrite)
        begin
            n.hrdata = read_word(n, ahb.haddr[7:0]);
        end
        n.hreadyout = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s <= '0;
            s.miso_oe_n <= 1'b1;
            s.hreadyout <= 1'b1;
            s.irq_mask <= IRQ_MASK_RST;
        end
        else
        begin
            s <= n;
        end
    end

    // outputs straight from the state register
    assign hreadyout = s.hreadyout;
    assign hrdata = s.hrdata;
    assign hresp = 1'b0 & s.hreadyout;
    assign miso = s.miso;
    assign miso_oe_n = s.miso_oe_n;
    assign irq = s.irq;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence frame_open;
        $rose(s.in_frame);
    endsequence

    sequence frame_close_ok;
        cs_rise && s.in_frame && !link_reset && !s.rref_s[1] && s.bits == FRAME_BITS && (^s.rx);
    endsequence

    resp_class_a: assert property (frame_open and $past(s.sel) == SEL_CMD |->
        s.last_tx[15:14] == CLASS_CMD) else $error("command reply class wrong"); // RQ1
    default_reg_a: assert property (frame_close_ok ##0 s.rx[15:14] == CLASS_REG |=>
        s.sel == SEL_REG) else $error("register reply not selected"); // RQ2
    first_zero_a: assert property (frame_open and $past(s.sel) == SEL_ZERO |->
        s.last_tx == RESP_AFTER_RESET) else $error("first reply not zero"); // RQ3
    hard_clear_a: assert property (s.rref_s[1] |=> !s.hard_flag)
        else $error("hard flag not cleared"); // RQ8
    soft_word_a: assert property (frame_open and $past(s.sel == SEL_REG && s.soft_flag) |->
        s.last_tx[15:14] == CLASS_REG && s.last_tx[0] && s.last_tx[2])
        else $error("soft reset reply wrong"); // RQ10
    cmd_bits_a: assert property (frame_open and $past(s.sel) == SEL_CMD |->
        s.last_tx[3:0] == $past(s.deploy_cmd) && s.last_tx[9:8] == $past(s.arm_flag))
        else $error("command reply bits wrong"); // RQ16
    fault_top_a: assert property (cs_rise && s.in_frame && !link_reset && s.bits != FRAME_BITS
        |=> s.sel == SEL_FAULT ##1 !cs_fall [*1] ##0 s.fault_cause == CAUSE_COUNT)
        else $error("count fault not flagged"); // RQ17
    miso_msb_a: assert property (frame_open |-> !s.miso_oe_n && s.miso == s.last_tx[15])
        else $error("first bit not MSB"); // RQ18
    echo_bit_a: assert property (frame_open and $past(s.sel) == SEL_REG |->
        s.last_tx[13] == 1'b0 && s.last_tx[12] == $past(s.wr_echo))
        else $error("echo bit wrong"); // RQ4
endmodule
`default_nettype wire

// ==== dv/ddsr_host_model.sv ====
`default_nettype none
// host side of the serial link: mode 0 master, link clock 160 ns
module ddsr_host_model (
    output logic sclk,
    output logic cs_n,
    output logic mosi,
    input wire logic miso,
    input wire logic miso_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF_NS = 80;
    localparam int GAP_NS = 200;

    ////////////////////////////////////////////////////////////////////////
    // idle levels: link clock parked low between frames, never free running
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // one framed transfer; nbits other than 16 is a deliberate miscount
    task automatic xfer(input logic [15:0] cmd, input int nbits, output logic [15:0] rsp,
        output logic oe_ok);
        int i;
        rsp = 16'h0000;
        oe_ok = 1'b1;
        #7; // keeps the link out of step with hclk
        cs_n = 1'b0;
        #GAP_NS;
        for (i = 0; i < nbits; i++)
        begin
            mosi = (i < 16) ? cmd[15 - i] : 1'b0;
            #HALF_NS;
            sclk = 1'b1;
            if (i < 16)
                rsp[15 - i] = miso;
            if (miso_oe_n !== 1'b0)
                oe_ok = 1'b0;
            #HALF_NS;
            sclk = 1'b0;
        end
        #HALF_NS;
        cs_n = 1'b1;
        mosi = ~mosi; // a released line must not keep showing its last bit
        #GAP_NS;
    endtask
endmodule
`default_nettype wire

// ==== dv/test_deploy_driver_spi_response.sv ====
`default_nettype none
`define CHK(nm, e, g) \
    begin \
        n_checks++; \
        if ((g) !== (e)) \
        begin \
            failures++; \
            $display("Error %s expected %h seen %h", nm, e, g); \
        end \
    end
module test_deploy_driver_spi_response;
    timeunit 1ns;
    timeprecision 1ps;
    import ddsr_pkg::*;
    logic hclk;
    logic hresetn;
    logic a_sel;
    logic a_write;
    logic [31:0] a_addr;
    logic [1:0] a_trans;
    logic [31:0] a_wdata;
    ddsr_ahb_req_t ahb;
    ddsr_spi_in_t spi_in;
    ddsr_pins_t pins;
    logic hreadyout;
    logic hresp;
    logic miso;
    logic miso_oe_n;
    logic irq;
    logic [31:0] hrdata;
    logic sclk;
    logic cs_n;
    logic mosi;
    int failures;
    int n_checks;

    ////////////////////////////////////////////////////////////////////////
    // single slave, so the bus hready is the slave's own hreadyout
    assign ahb = '{hsel: a_sel, haddr: a_addr, htrans: a_trans, hwrite: a_write,
        hsize: 3'h2, hready: hreadyout, hwdata: a_wdata};
    assign spi_in = '{sclk: sclk, cs_n: cs_n, mosi: mosi};

    ddsr_core #(.STRETCH_CYC(20)) dut_u (.hclk(hclk), .hresetn(hresetn), .ahb(ahb),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .spi_in(spi_in),
        .miso(miso), .miso_oe_n(miso_oe_n), .pins(pins), .irq(irq));
    ddsr_host_model host_u (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
        .miso_oe_n(miso_oe_n));

    // 50 mhz system clock
    initial
    begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    ////////////////////////////////////////////////////////////////////////
    // odd parity over all 16 bits, carried in bit 13
    function automatic logic [15:0] par(input logic [15:0] x);
        logic [15:0] y;
        y = x & 16'hDFFF;
        y[13] = ~^y;
        return y;
    endfunction

    task automatic close_out();
        if (failures == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // one ahb single transfer, waiting on hready in both phases
    task automatic ahb_do(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
        output logic [31:0] rd);
        a_sel <= 1'b1;
        a_addr <= {24'h000000, ad};
        a_trans <= 2'h2;
        a_write <= wr;
        // no local limit: only the watchdog may end a wait
        do
        begin
            @(posedge hclk);
        end
        while (hreadyout !== 1'b1);
        a_sel <= 1'b0;
        a_trans <= 2'h0;
        a_wdata <= wd;
        do
        begin
            @(posedge hclk);
        end
        while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        logic [31:0] r;
        ahb_do(1'b1, ad, d, r);
    endtask

    task automatic rd_chk(input logic [7:0] ad, input logic [31:0] e, input string nm);
        logic [31:0] r;
        ahb_do(1'b0, ad, 32'h00000000, r);
        `CHK(nm, e, r)
    endtask

    task automatic send(input logic [15:0] cmd, input int nb);
        logic [15:0] r;
        logic ok;
        host_u.xfer(cmd, nb, r, ok);
        @(posedge hclk);
    endtask

    task automatic xchk(input logic [15:0] cmd, input logic [15:0] e, input string nm);
        logic [15:0] r;
        logic ok;
        host_u.xfer(cmd, 16, r, ok);
        `CHK(nm, e, r)
        `CHK("miso enable", 1'b1, ok)
        @(posedge hclk);
    endtask

    task automatic irq_is(input logic e);
        repeat (3) @(posedge hclk);
        #1;
        `CHK("irq", e, irq)
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd_chk(OFF_IRQ_MASK, 32'h00000000, "irq mask");
        rd_chk(8'h20, 32'h00000000, "unmapped");
        `CHK("hresp", 1'b0, hresp)
        xchk(par(16'h0000), RESP_AFTER_RESET, "first reply");
        xchk(par(16'h0000), 16'h0006, "read reply");
        rd_chk(OFF_LAST_FRAME, 32'h20000006, "last frame");
    endtask

    // reset pin and ground loss restart the link; resistor fault clears the flag only
    task automatic t_pins();
        int k;
        for (k = 0; k < 3; k++)
        begin
            pins.external_reset_pin_n <= (k != 0);
            pins.ground_loss <= (k == 1);
            pins.reference_resistor_fault <= (k == 2);
            repeat (10) @(posedge hclk);
            pins.external_reset_pin_n <= 1'b1;
            pins.ground_loss <= 1'b0;
            pins.reference_resistor_fault <= 1'b0;
            repeat (10) @(posedge hclk);
            xchk(par(16'h0000), (k == 2) ? 16'h0004 : 16'h0000, "pin reply");
            xchk(par(16'h0000), 16'h0006, "hard flag set");
        end
    endtask

    task automatic t_soft();
        xchk(par(16'h18AA), 16'h0006, "before soft");
        xchk(par(16'h1855), 16'h1806, "after first code");
        xchk(par(16'h0000), 16'h0007, "after second code");
        xchk(par(16'h0000), 16'h0006, "soft flag drops");
    endtask

    // every condition and stretch code, each reply seen in the following frame
    task automatic t_stretch();
        int i;
        logic [15:0] w;
        logic [15:0] prev;
        prev = 16'h0006;
        for (i = 0; i < 8; i++)
        begin
            w = 16'h1000 | 16'(i << 8);
            xchk(par(w), prev, "stretch reply");
            prev = w | 16'h0006;
        end
        xchk(par(16'h0000), prev, "last stretch");
        xchk(par(16'h0000), 16'h0706, "read echo");
        rd_chk(OFF_LINK_STATE, 32'h000041C0, "link state");
    endtask

    // arming and deploy enable are waited past deglitch plus the longest stretch
    task automatic t_cmd();
        logic [3:0] arm [4] = '{4'h1, 4'h4, 4'hC, 4'h0};
        logic [1:0] flg [4] = '{2'h1, 2'h2, 2'h2, 2'h0};
        logic dep [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
        logic [3:0] nib [4] = '{4'h1, 4'h2, 4'h4, 4'hF};
        int i;
        for (i = 0; i < 4; i++)
        begin
            pins.arm_chan <= arm[i];
            pins.deploy_enable_pin <= dep[i];
            repeat (300) @(posedge hclk);
            xchk(par({12'h400, nib[i]}), (i == 0) ? 16'h0706 :
                {3'h2, dep[i], 2'h0, flg[i], 4'h0, nib[i - 1]}, "cmd reply");
        end
        xchk(par(16'h0000), {3'h2, dep[3], 2'h0, flg[3], 4'h0, nib[3]}, "no arm");
    endtask

    task automatic t_fault();
        send(par(16'h1300) ^ 16'h2000, 16);
        xchk(par(16'h0000), 16'hE000, "parity fault");
        xchk(par(16'h0000), 16'h0706, "settings kept");
        send(par(16'h0000), 15);
        xchk(par(16'h0000), 16'hF000, "count fault");
        xchk(par(16'h8000), 16'h0706, "diag sent");
        xchk(par(16'hC000), 16'h8000, "diag reply");
        xchk(par(16'h0000), 16'hC000, "status reply");
    endtask

    // frame-done event: masked, then unmasked, then cleared by writing one
    task automatic t_irq();
        wr(OFF_IRQ_STATUS, 32'h0000001F);
        rd_chk(OFF_IRQ_STATUS, 32'h00000000, "status clear");
        send(par(16'h0000), 16);
        irq_is(1'b0);
        rd_chk(OFF_IRQ_STATUS, 32'h00000001, "frame status");
        wr(OFF_IRQ_MASK, 32'h00000001);
        irq_is(1'b1);
        wr(OFF_IRQ_STATUS, 32'h00000001);
        irq_is(1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        failures = 0;
        n_checks = 0;
        hresetn = 1'b0;
        a_sel = 1'b0;
        a_write = 1'b0;
        a_addr = 32'h00000000;
        a_trans = 2'h0;
        a_wdata = 32'h00000000;
        pins = '{arm_chan: 4'h0, deploy_enable_pin: 1'b0, external_reset_pin_n: 1'b1,
            ground_loss: 1'b0, reference_resistor_fault: 1'b0};
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (8) @(posedge hclk);
        t_reset();
        t_pins();
        t_soft();
        t_stretch();
        t_cmd();
        t_fault();
        t_irq();
        close_out();
    end

    // the whole run needs about 150 us; a hang is cut well after that
    initial
    begin
        #500000;
        failures++;
        close_out();
    end
endmodule
`default_nettype wire
